// ==== bench/adp_core_tb.sv ====
// self-checking bench for the stream datapath core
// assumes the source model beside it; no registers, one clock
`timescale 1ns/100ps
`default_nettype none
module adp_core_tb;
  import adp_pkg::*;
  logic i_clk = 1'b0, i_srst = 1'b1, i_unmute = 1'b0, i_gain_en = 1'b0;
  logic [1:0] i_rate = 2'h0;
  logic [CORE_W-1:0] i_gain = CORE_ONE;
  logic in_valid, in_ready, o_out_valid, o_busy;
  logic [IO_W-1:0] in_data, o_out_data, d;
  logic [IO_W-1:0] expq[$];
  logic [IO_W-1:0] corner[4] = '{24'h7f_ffff, 24'h80_0000, 24'h00_0001, 24'hff_ffff};
  logic [CORE_W-1:0] gains[5] = '{28'h080_0000, 28'h100_0000, 28'h200_0000, 28'h400_0000,
                                  28'hf80_0000};
  integer seed = 32'ha8a7623a;
  int num_errors = 0, tests_run = 0, cyc = 0, last = -1, spc = 0, refused = 0, i;
  bit spc_on = 1'b0;
  logic busy_q = 1'b0;
  always #2 i_clk = ~i_clk;
  adp_src_model src (.i_clk(i_clk), .i_ready(in_ready), .o_valid(in_valid), .o_data(in_data));
  adp_core uut (.i_clk(i_clk), .i_srst(i_srst), .i_in_valid(in_valid), .o_in_ready(in_ready),
    .i_in_data(in_data), .i_rate(i_rate), .i_unmute(i_unmute), .i_gain(i_gain),
    .i_gain_en(i_gain_en), .o_out_valid(o_out_valid), .o_out_data(o_out_data), .o_busy(o_busy));
  // ==========================================================
  // checking helpers
  task check(string nm, logic [CORE_W-1:0] e, logic [CORE_W-1:0] s);
    tests_run++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask : check
  function automatic logic [IO_W-1:0] exp_out(logic [IO_W-1:0] x, logic un, logic ge,
                                               logic [CORE_W-1:0] g);
    logic signed [55:0] p;
    p = $signed({{32{x[23]}}, x});
    if (ge) p = (p * $signed({{28{g[27]}}, g})) >>> FRAC_W;
    if (!un) return '0;
    if (p > 56'sh7f_ffff) return OUT_MAX;
    if (p < -56'sh80_0000) return OUT_MIN;
    return p[IO_W-1:0];
  endfunction : exp_out
  task print_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // output monitor; spacing only judged while the fifo stays fed
  always @(negedge i_clk) if (!i_srst) begin
    cyc++;
    if (in_ready === 1'b0) refused++;
    if (o_out_valid === 1'b1) begin
      if (expq.size() == 0) check("extra_output", 28'h1, 28'h0);
      else check("out_data", {4'h0, expq.pop_front()}, {4'h0, o_out_data});
      if (spc_on && last >= 0) check("spacing", 28'(spc), 28'(cyc - last));
      check("busy_before_out", 28'h1, 28'(busy_q));
      check("busy_at_out", 28'h0, 28'(o_busy));
      last = cyc;
    end
    busy_q = o_busy;
  end
  task automatic batch(int n, logic [1:0] r, logic un, logic ge, logic [CORE_W-1:0] g, int gp);
    int k;
    @(negedge i_clk);
    i_rate = r;
    i_unmute = un;
    i_gain_en = ge;
    i_gain = g;
    src.gap = gp;
    repeat (3) @(negedge i_clk);
    spc = (r == 2'h1) ? 258 : (r == 2'h2) ? 130 : 514;
    spc_on = (gp == 0);
    last = -1;
    for (k = 0; k < n; k++) begin
      d = (k < 4) ? corner[k] : IO_W'($random(seed));
      expq.push_back(exp_out(d, un, ge, g));
      src.q.push_back(d);
    end
    k = 0;
    while (expq.size() > 0 && k < 20 * 514) begin
      @(negedge i_clk);
      k++;
    end
    check("pending", 28'h0, 28'(expq.size()));
  endtask : batch
  initial begin
    #240000;
    $display("ERROR watchdog expected done seen hang");
    num_errors++;
    print_verdict;
  end
  initial begin
    repeat (4) @(negedge i_clk);
    check("reset_outs", 28'h000_0001, {o_out_valid, o_out_data, o_busy, in_ready});
    i_srst = 1'b0;
    batch(6, 2'h0, 1'b0, 1'b0, CORE_ONE, 1);
    for (i = 0; i < 4; i++) batch(10, 2'(i), 1'b1, 1'b0, CORE_ONE, 0);
    check("refused_seen", 28'h1, 28'(refused > 0));
    for (i = 0; i < 5; i++) batch(6, 2'h2, 1'b1, 1'b1, gains[i], i % 3);
    print_verdict;
  end
endmodule : adp_core_tb
`default_nettype wire

// ==== bench/adp_src_model.sv ====
// sample source standing in for the serial input port
// assumes the core samples valid and ready on the rising clock edge
`timescale 1ns/100ps
`default_nettype none
module adp_src_model
  import adp_pkg::*;
(
  input  wire logic                     i_clk,    // core clock
  input  wire logic                     i_ready,  // core can take a sample
  output logic                          o_valid,  // sample offered
  output logic [adp_pkg::IO_W-1:0]      o_data    // sample word
);
  logic [IO_W-1:0] q[$];
  int              gap = 0;
  int              wait_n = 0;
  logic            taken = 1'b0;
  logic            v;
  logic [IO_W-1:0] d;
  initial begin
    o_valid = 1'b0;
    o_data  = '0;
  end
  always @(posedge i_clk) taken <= o_valid && i_ready;
  // ==========================================================
  // offer held until taken; idle data is scrambled, never left stale
  always @(negedge i_clk) begin
    v = o_valid;
    d = o_data;
    if (v && taken) begin
      v      = 1'b0;
      d      = ~d;
      wait_n = gap;
    end
    if (!v && wait_n > 0) wait_n--;
    else if (!v && q.size() > 0) begin
      d = q.pop_front();
      v = 1'b1;
    end
    o_valid <= v;
    o_data  <= d;
  end
endmodule : adp_src_model
`default_nettype wire

// ==== hdl/adp_core.sv ====
// stream datapath: sample in, 5.23 core processing, clipped sample out
// assumes samples from same-clock serial-port logic; host mutes by control pins
// Function
// - samples enter and leave as 24-bit words; four headroom bits held inside
// - parameters and data share signed 5.23 fixed-point format
// - core range spans -16 to +16 minus one lsb; -1 is 0xF800000
// - 24-bit input samples are sign-extended to the 28-bit core word
// - clipper drops headroom bits, giving 24-bit output from -1 to 1-lsb
// - fixed budget of 512 instruction cycles runs every single-rate sample period
// - rate setting shortens cycles per sample for double or quad rate input
// - default program passes input through; outputs muted until unmuted
`timescale 1ns/100ps
`default_nettype none
module adp_core
  import adp_pkg::*;
#(
  parameter int IN_W = adp_pkg::IO_W
) (
  input  wire logic                     i_clk,       // 250 MHz clock
  input  wire logic                     i_srst,      // sync reset, active high
  input  wire logic                     i_in_valid,  // input sample valid
  output logic                          o_in_ready,  // fifo can take a sample
  input  wire logic [adp_pkg::IO_W-1:0] i_in_data,   // 24-bit input sample
  input  wire logic [1:0]               i_rate,      // 0 single, 1 double, 2 quad
  input  wire logic                     i_unmute,    // high releases the mute
  input  wire logic [adp_pkg::CORE_W-1:0] i_gain,    // 5.23 gain parameter
  input  wire logic                     i_gain_en,   // use gain instead of pass
  output logic                          o_out_valid, // one-cycle output strobe
  output logic [adp_pkg::IO_W-1:0]      o_out_data,  // clipped 24-bit sample
  output logic                          o_busy       // program running
);
  import adp_pkg::*;

  // ==========================================================
  // input buffer
  logic              fifo_valid;
  logic [IO_W-1:0]   fifo_data;
  logic              take;

  adp_fifo #(
    .WIDTH (IO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_valid (i_in_valid),
    .o_ready (o_in_ready),
    .i_data  (i_in_data),
    .o_valid (fifo_valid),
    .i_ready (take),
    .o_data  (fifo_data)
  );

  // ==========================================================
  // sequencing
  adp_state_t         state_r;
  adp_state_t         state_nxt;
  logic [CYC_W-1:0]   pc_r;
  logic [CYC_W-1:0]   budget_r;
  logic [CORE_W-1:0]  acc_r;
  logic [2*CORE_W-1:0] prod;
  logic [CORE_W-1:0]  prod_q;
  logic               unmute_s1_r;
  logic               unmute_r;
  logic [CYC_W:0]     run_len_r;
  logic [IO_W-1:0]    out_r;
  logic               out_v_r;

  // cycles per sample; undefined code falls back to full budget
  wire [CYC_W:0] cyc_single = (CYC_W+1)'(CYC_FULL);
  wire [CYC_W:0] cyc_sel    = (i_rate == RATE_DOUBLE) ? cyc_single >> 1 :
                              (i_rate == RATE_QUAD)   ? cyc_single >> 2 :
                              cyc_single;
  wire [CYC_W-1:0] budget_last = CYC_W'(cyc_sel - 1'b1);

  assign take = (state_r == ADP_IDLE) && fifo_valid;

  // sign extension keeps 1.0 input mapped onto core 1.0
  wire [CORE_W-1:0] in_ext = {{HEAD_W{fifo_data[IO_W-1]}}, fifo_data};

  // signed 5.23 multiply, product re-aligned by the fraction width
  // both factors widened first so the full 56-bit product survives
  assign prod   = $signed({{CORE_W{acc_r[CORE_W-1]}}, acc_r}) *
                  $signed({{CORE_W{i_gain[CORE_W-1]}}, i_gain});
  assign prod_q = prod[FRAC_W +: CORE_W];

  // ==========================================================
  // clipper: top bits must all equal the output sign, else saturate
  wire [HEAD_W:0] top_bits = acc_r[CORE_W-1 -: HEAD_W+1];
  wire            in_range = (&top_bits) || ~(|top_bits);
  wire [IO_W-1:0] clipped  = in_range ? acc_r[IO_W-1:0] :
                             (acc_r[CORE_W-1] ? OUT_MIN : OUT_MAX);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ADP_IDLE: begin
        if (fifo_valid) begin
          state_nxt = ADP_RUN;
        end
      end
      ADP_RUN: begin
        if (pc_r == budget_r) begin
          state_nxt = ADP_EMIT;
        end
      end
      ADP_EMIT: state_nxt = ADP_IDLE;
      default:  state_nxt = ADP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r  <= ADP_IDLE;
      pc_r     <= '0;
      budget_r <= '1;
      acc_r    <= '0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        acc_r    <= in_ext;
        pc_r     <= '0;
        budget_r <= budget_last;  // rate latched per sample, no mid-frame change
      end else if (state_r == ADP_RUN) begin
        pc_r <= pc_r + 1'b1;
        // the built-in program is a pass-through; the single gain step is
        // the only instruction that touches the word
        if (pc_r == '0 && i_gain_en) begin
          acc_r <= prod_q;
        end
      end
    end
  end

  // ==========================================================
  // output stage, muted from reset until released
  // mute pin comes from the host side, so it passes two flops first
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      unmute_s1_r <= 1'b0;
      unmute_r    <= 1'b0;
      out_r       <= '0;
      out_v_r     <= 1'b0;
    end else begin
      unmute_s1_r <= i_unmute;
      unmute_r    <= unmute_s1_r;
      out_v_r  <= (state_r == ADP_EMIT);
      if (state_r == ADP_EMIT) begin
        out_r <= unmute_r ? clipped : '0;
      end
    end
  end

  assign o_out_valid = out_v_r;
  assign o_out_data  = out_r;
  assign o_busy      = (state_r != ADP_IDLE);

  // ==========================================================
  // run length watch: counts consecutive run cycles for the budget checks
  // kept apart from pc_r so a broken counter cannot hide its own fault
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      run_len_r <= '0;
    end else if (state_r == ADP_RUN) begin
      run_len_r <= run_len_r + 1'b1;
    end else begin
      run_len_r <= '0;
    end
  end

  // ==========================================================
  // checks
  a_out_sat_pos: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_EMIT && unmute_r && !acc_r[CORE_W-1] && !in_range)
      |=> o_out_data == OUT_MAX)
    else $error("positive overflow not saturated");
  a_out_sat_neg: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_EMIT && unmute_r && acc_r[CORE_W-1] && !in_range)
      |=> o_out_data == OUT_MIN)
    else $error("negative overflow not saturated");
  a_clip_pass: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_EMIT && unmute_r && in_range)
      |=> o_out_data == $past(acc_r[IO_W-1:0]))
    else $error("in-range value altered by clipper");
  a_sign_ext: assert property (@(posedge i_clk) disable iff (i_srst)
    take |=> acc_r == {{HEAD_W{$past(fifo_data[IO_W-1])}}, $past(fifo_data)})
    else $error("input not sign-extended");
  a_mute_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_EMIT && !unmute_r) |=> o_out_data == '0)
    else $error("muted output not zero");
  a_budget_full: assert property (@(posedge i_clk) disable iff (i_srst)
    (take && i_rate == RATE_SINGLE) |=> budget_r == CYC_W'(CYC_FULL - 1))
    else $error("single rate budget wrong");
  a_budget_quad: assert property (@(posedge i_clk) disable iff (i_srst)
    (take && i_rate == RATE_QUAD) |=> budget_r == CYC_W'(CYC_FULL/4 - 1))
    else $error("quad rate budget wrong");
  a_run_emit: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_RUN && pc_r == budget_r) |=> state_r == ADP_EMIT ##1 o_out_valid)
    else $error("sample not emitted after budget");
  a_unity_gain: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_RUN && pc_r == '0 && i_gain_en && i_gain == CORE_ONE)
      |=> acc_r == $past(acc_r))
    else $error("unity gain changed the word");

  // ==========================================================
  // rate and budget checks
  a_budget_double: assert property (@(posedge i_clk) disable iff (i_srst)
    (take && i_rate == RATE_DOUBLE) |=> budget_r == CYC_W'(CYC_FULL/2 - 1))
    else $error("double rate budget wrong");

  // the spare rate code must behave like single rate, never shorter
  a_budget_spare: assert property (@(posedge i_clk) disable iff (i_srst)
    (take && i_rate == 2'h3) |=> budget_r == CYC_W'(CYC_FULL - 1))
    else $error("spare rate code budget wrong");

  a_budget_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_RUN) |=> $stable(budget_r))
    else $error("budget changed during a sample");

  a_pc_bound: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_RUN) |-> pc_r <= budget_r)
    else $error("program counter ran past budget");

  a_pc_start: assert property (@(posedge i_clk) disable iff (i_srst)
    take |=> (pc_r == '0 && state_r == ADP_RUN))
    else $error("program did not start at zero");

  a_run_len: assert property (@(posedge i_clk) disable iff (i_srst)
    run_len_r <= (CYC_W+1)'(CYC_FULL))
    else $error("run exceeded full budget");

  a_run_exact: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_EMIT) |-> run_len_r == (CYC_W+1)'(budget_r) + 1'b1)
    else $error("run length differs from budget");

  // ==========================================================
  // sequencing checks
  a_state_onehot: assert property (@(posedge i_clk) disable iff (i_srst)
    $onehot(state_r))
    else $error("state register not one-hot");

  a_emit_once: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_EMIT) |=> state_r == ADP_IDLE)
    else $error("emit state held too long");

  a_out_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
    o_out_valid |=> !o_out_valid)
    else $error("output strobe longer than one cycle");

  a_out_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_out_valid |-> $stable(o_out_data))
    else $error("output data moved without strobe");

  // ==========================================================
  // numeric, unmute synchroniser and fifo ready checks
  a_head_sign: assert property (@(posedge i_clk) disable iff (i_srst)
    take |=> (&acc_r[CORE_W-1 -: HEAD_W+1]) || !(|acc_r[CORE_W-1 -: HEAD_W+1]))
    else $error("fresh sample does not fit output range");

  a_gain_step: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_RUN && pc_r == '0 && i_gain_en) |=> acc_r == $past(prod_q))
    else $error("gain step result lost");

  // pass-through program: the word may only change on the gain step
  a_pass_through: assert property (@(posedge i_clk) disable iff (i_srst)
    (state_r == ADP_RUN && !(pc_r == '0 && i_gain_en)) |=> $stable(acc_r))
    else $error("word changed outside the gain step");

  a_unmute_sync: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(unmute_r) |-> $past(i_unmute, 2))
    else $error("unmute bypassed the synchroniser");

  a_in_ready: assert property (@(posedge i_clk) disable iff (i_srst)
    (!o_in_ready) |-> fifo_valid)
    else $error("fifo refuses while empty");
endmodule : adp_core
`default_nettype wire

// ==== hdl/adp_fifo.sv ====
// small synchronous FIFO holding input samples
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module adp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,    // clock
  input  wire logic             i_srst,   // sync reset
  input  wire logic             i_valid,  // write request
  output logic                  o_ready,  // not full
  input  wire logic [WIDTH-1:0] i_data,   // write data
  output logic                  o_valid,  // not empty
  input  wire logic             i_ready,  // read request
  output logic      [WIDTH-1:0] o_data    // head word, registered
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic [WIDTH-1:0] head_r;
  wire              wr_en = i_valid && o_ready;
  wire              rd_en = i_ready && o_valid;
  wire [AW-1:0]     rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;

  assign o_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_valid = (cnt_r != '0);
  assign o_data  = head_r;

  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      mem_r[wp_r] <= i_data;
    end
  end

  // head register kept current so read data always comes from a flop
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      head_r <= '0;
    end else begin
      if (wr_en) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (rd_en) begin
        rp_r <= rp_nxt;
      end
      cnt_r <= cnt_r + (AW+1)'(wr_en) - (AW+1)'(rd_en);
      if (rd_en) begin
        head_r <= (wr_en && cnt_r == (AW+1)'(1)) ? i_data : mem_r[rp_nxt];
      end else if (wr_en && cnt_r == '0) begin
        head_r <= i_data;
      end else begin
        head_r <= mem_r[rp_r];
      end
    end
  end
endmodule : adp_fifo
`default_nettype wire

// ==== pkg/adp_pkg.sv ====
// constants and types for the audio numeric datapath
// assumes one 250 MHz clock domain and no software-visible registers
package adp_pkg;
  // ==========================================================
  // word formats
  localparam int IO_W    = 24;   // sample width at the ports
  localparam int HEAD_W  = 4;    // headroom bits
  localparam int CORE_W  = IO_W + HEAD_W;  // 5.23 core word
  localparam int FRAC_W  = 23;
  localparam logic [IO_W-1:0]   OUT_MAX  = 24'h7f_ffff;
  localparam logic [IO_W-1:0]   OUT_MIN  = 24'h80_0000;
  localparam logic [CORE_W-1:0] CORE_ONE = 28'h080_0000;
  // ==========================================================
  // execution budget
  localparam int CYC_FULL = 512;
  localparam int CYC_W    = 10;
  localparam logic [1:0] RATE_SINGLE = 2'h0;
  localparam logic [1:0] RATE_DOUBLE = 2'h1;
  localparam logic [1:0] RATE_QUAD   = 2'h2;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    ADP_IDLE = 3'b001,
    ADP_RUN  = 3'b010,
    ADP_EMIT = 3'b100
  } adp_state_t;
endpackage : adp_pkg
